// ==== vfdfc_pkg.sv ====
package vfdfc_pkg;
   // command addresses; bit 7 of the command byte marks a read
   localparam logic [7:0] VFDFC_ADDR_CONFIG   = 8'h04;
   localparam logic [7:0] VFDFC_ADDR_FONT     = 8'h05;
   localparam logic [7:0] VFDFC_ADDR_CURSOR   = 8'h0f;
   localparam logic [7:0] VFDFC_ADDR_CHAR_LO  = 8'h20;
   localparam logic [7:0] VFDFC_ADDR_CHAR_SHI = 8'h4f;
   localparam logic [7:0] VFDFC_ADDR_CHAR_HI  = 8'h7f;
   localparam int         VFDFC_RD_BIT        = 7;

   // serial frame: 8 command bits then 8 data bits
   localparam logic [4:0] VFDFC_CMD_BITS   = 5'h08;
   localparam logic [4:0] VFDFC_FRAME_BITS = 5'h10;

   // storage sizes
   localparam int VFDFC_GLYPHS   = 24;
   localparam int VFDFC_ENTRIES  = 48;
   localparam int VFDFC_CHARS    = 96;
   localparam int VFDFC_ROW_LEN  = 48;

   // font pointer
   localparam logic [7:0] VFDFC_PTR_BAD_LO = 8'hb0;
   localparam logic [5:0] VFDFC_PTR_FIRST  = 6'h00;
   localparam logic [5:0] VFDFC_PTR_LAST   = 6'h2f;
   localparam int         VFDFC_PTR_FLAG   = 7;

   // cursor field
   localparam int         VFDFC_CUR_BLINK  = 7;
   localparam logic [6:0] VFDFC_CUR_ROW2_LO = 7'h30;
   localparam logic [6:0] VFDFC_CUR_OFF_LO  = 7'h60;
   localparam logic [7:0] VFDFC_CURSOR_RST  = 8'h60;

   // configuration fields
   localparam int VFDFC_CFG_RUN     = 0;
   localparam int VFDFC_CFG_FONT    = 1;
   localparam int VFDFC_CFG_BRATE   = 2;
   localparam int VFDFC_CFG_BRST    = 3;
   localparam int VFDFC_CFG_CLEAR   = 4;
   localparam int VFDFC_CFG_LOCK    = 5;
   localparam int VFDFC_CFG_ROW2    = 6;
   localparam logic [7:0] VFDFC_CFG_RST = 8'h00;

   // character byte
   localparam int VFDFC_DP_BIT = 7;

   // blink timing
   localparam int VFDFC_CLK_KHZ       = 100000;
   localparam int VFDFC_BLINK_SLOW_MS = 1000;
   localparam int VFDFC_BLINK_FAST_MS = 500;
   localparam int VFDFC_BLINK_SLOW_CYC = VFDFC_BLINK_SLOW_MS * VFDFC_CLK_KHZ;
   localparam int VFDFC_BLINK_FAST_CYC = VFDFC_BLINK_FAST_MS * VFDFC_CLK_KHZ;

   // power-up seven-segment patterns, first entry of each glyph
   localparam logic [6:0] VFDFC_FONT_INIT [VFDFC_GLYPHS] = '{
      7'h7e, 7'h30, 7'h6d, 7'h79, 7'h33, 7'h5b, 7'h5f, 7'h70,
      7'h7f, 7'h7b, 7'h77, 7'h1f, 7'h4e, 7'h3d, 7'h4f, 7'h47,
      7'h0d, 7'h15, 7'h76, 7'h1d, 7'h05, 7'h4f, 7'h1c, 7'h00};
endpackage

// ==== vfdfc_regs.sv ====
`timescale 1ns/1ps
// What this block does
// - holds 24 user glyphs as 48 seven-bit entries, two per glyph
// - character low seven bits pick a glyph, bit seven lights point
// - characters at 0x20-0x4F single-row, 0x20-0x7F double-row
// - font entries preload at reset; first sixteen glyphs are hex
// - every font entry is reached from the host only through port register 0x05
// - pointer loads any of 48 locations and cannot be read back
// - port read returns entry at current pointer
// - port write with msb set loads pointer, else stores data
// - pointer advances after each valid font read or write
// - after location 0x2f, font data is ignored until pointer reload
// - pointer load of 0xb0-0xff selects the first location
// - entries are seven bits and unused ones keep scratch values
// - 48 or 96 cursors; only the selected one lights
// - cursor low bits give position; msb set blinks first half
// - positions 0x00-0x2f row one, 0x30-0x5f row two
// - positions 0x60-0x7f turn every cursor off
// - each grid packs four annunciators as 2-bit fields in a byte
// - annunciators show in single-row mode only
// - config holds run, lock, blink rate, rows; clear and blink restart act on write and read back 0
// - config font bit chooses fourteen or sixteen segment table
// - command 0x85 reads entry with msb clear then advances
module vfdfc_regs
   import vfdfc_pkg::*;
#(
   parameter int BLINK_SLOW_CYC = VFDFC_BLINK_SLOW_CYC,
   parameter int BLINK_FAST_CYC = VFDFC_BLINK_FAST_CYC
) (
   input  wire logic        clk_sys,    // system clock
   input  wire logic        rst,        // async reset, high
   input  wire logic        cs_n,       // serial select, low
   input  wire logic        sclk,       // serial clock
   input  wire logic        din,        // serial data in
   output logic             dout,       // serial data out
   input  wire logic [6:0]  disp_idx,   // digit position to fetch
   output logic [6:0]       disp_glyph, // glyph code of that digit
   output logic             disp_dp,    // decimal point lit
   output logic             disp_cursor,// cursor lit
   output logic [3:0]       ann_lit,    // annunciator segments lit
   input  wire logic [4:0]  glyph_idx,  // user glyph to fetch
   output logic [13:0]      glyph_bits, // both entries of that glyph
   output logic             font_sel,   // 1 selects sixteen segment table
   output logic             run,        // 0 while in shutdown
   output logic             row2_mode,  // double-row mode
   output logic             blink_on    // first half of blink period
);
   import vfdfc_pkg::*;

   localparam int BW = $clog2(BLINK_SLOW_CYC + 1);

   logic             sclk_ff;
   logic             cs_n_ff;
   logic [4:0]       cnt_ff;
   logic [15:0]      shift_ff;
   logic [7:0]       rd_ff;
   logic             dout_ff;
   logic [7:0]       cfg_ff;
   logic [7:0]       cursor_ff;
   logic [5:0]       fptr_ff;
   logic             fdone_ff;
   logic [6:0]       font_ff [VFDFC_ENTRIES];
   logic [7:0]       chr_ff [VFDFC_CHARS];
   logic [BW-1:0]    blink_ff;
   logic [6:0]       glyph_ff;
   logic             dp_ff;
   logic             cur_ff;
   logic [3:0]       ann_ff;
   logic [13:0]      gbits_ff;

   logic             sclk_rise;
   logic             sclk_fall;
   logic             frame_end;
   logic             wr_evt;
   logic             rd_evt;
   logic [7:0]       cmd;
   logic [7:0]       wdata;
   logic [7:0]       cmd_now;
   logic [7:0]       rd_sel;
   logic             chr_hit;
   logic [6:0]       chr_idx;
   logic             font_wr;
   logic             font_ptr_wr;
   logic             font_rd;
   logic             clear_req;
   logic             brst_req;
   logic [BW-1:0]    blink_period;
   logic [BW-1:0]    nxt_blink;

   assign sclk_rise = sclk & ~sclk_ff;
   assign sclk_fall = ~sclk & sclk_ff;
   assign frame_end = cs_n & ~cs_n_ff & (cnt_ff == VFDFC_FRAME_BITS);
   assign cmd       = shift_ff[15:8];
   assign wdata     = shift_ff[7:0];
   assign wr_evt    = frame_end & ~cmd[VFDFC_RD_BIT];
   assign rd_evt    = frame_end & cmd[VFDFC_RD_BIT];
   assign cmd_now   = {shift_ff[6:0], din};
   assign chr_idx   = 7'(cmd[6:0] - VFDFC_ADDR_CHAR_LO[6:0]);

   // upper half belongs to row two or annunciators, both live in one array
   always_comb begin
      chr_hit = (cmd[6:0] >= VFDFC_ADDR_CHAR_LO[6:0]) &&
                (cmd[6:0] <= (row2_mode ? VFDFC_ADDR_CHAR_HI[6:0]
                                        : VFDFC_ADDR_CHAR_HI[6:0]));
   end

   assign font_ptr_wr = wr_evt & (cmd == VFDFC_ADDR_FONT)
                        & wdata[VFDFC_PTR_FLAG];
   assign font_wr     = wr_evt & (cmd == VFDFC_ADDR_FONT)
                        & ~wdata[VFDFC_PTR_FLAG] & ~fdone_ff;
   assign font_rd     = rd_evt & (cmd[6:0] == VFDFC_ADDR_FONT[6:0])
                        & ~fdone_ff;
   assign clear_req   = wr_evt & (cmd == VFDFC_ADDR_CONFIG)
                        & wdata[VFDFC_CFG_CLEAR];
   assign brst_req    = wr_evt & (cmd == VFDFC_ADDR_CONFIG)
                        & wdata[VFDFC_CFG_BRST];

   // serial front end; frames of other lengths are dropped
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sclk_ff  <= 1'b0;
         cs_n_ff  <= 1'b1;
         cnt_ff   <= 5'h00;
         shift_ff <= 16'h0000;
      end else begin
         sclk_ff <= sclk;
         cs_n_ff <= cs_n;
         if (cs_n) begin
            cnt_ff <= 5'h00;
         end else if (sclk_rise && cnt_ff != 5'h1f) begin
            cnt_ff   <= cnt_ff + 5'h01;
            shift_ff <= {shift_ff[14:0], din};
         end
      end
   end

   // read data picked at the 8th rise; last address bit is still on din
   always_comb begin
      rd_sel = 8'h00;
      if (cmd_now[6:0] == VFDFC_ADDR_CONFIG[6:0]) begin
         rd_sel = cfg_ff;
      end else if (cmd_now[6:0] == VFDFC_ADDR_FONT[6:0]) begin
         rd_sel = {1'b0, font_ff[fptr_ff]};
      end else if (cmd_now[6:0] == VFDFC_ADDR_CURSOR[6:0]) begin
         rd_sel = cursor_ff;
      end else if (cmd_now[6:0] >= VFDFC_ADDR_CHAR_LO[6:0]) begin
         rd_sel = chr_ff[7'(cmd_now[6:0] - VFDFC_ADDR_CHAR_LO[6:0])];
      end
   end

   // data goes out msb first, changing on falling serial clock
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rd_ff   <= 8'h00;
         dout_ff <= 1'b0;
      end else if (cs_n) begin
         dout_ff <= 1'b0;
      end else if (sclk_rise && cnt_ff == 5'(VFDFC_CMD_BITS - 5'h01)
                   && shift_ff[6]) begin
         rd_ff <= rd_sel;
      end else if (sclk_fall && cnt_ff >= VFDFC_CMD_BITS
                   && cnt_ff < VFDFC_FRAME_BITS) begin
         dout_ff <= rd_ff[7];
         rd_ff   <= {rd_ff[6:0], 1'b0};
      end
   end
   assign dout = dout_ff;

   // configuration; lock freezes font select and row mode
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cfg_ff <= VFDFC_CFG_RST;
      end else if (wr_evt && cmd == VFDFC_ADDR_CONFIG) begin
         cfg_ff[VFDFC_CFG_RUN]   <= wdata[VFDFC_CFG_RUN];
         cfg_ff[VFDFC_CFG_BRATE] <= wdata[VFDFC_CFG_BRATE];
         cfg_ff[VFDFC_CFG_LOCK]  <= wdata[VFDFC_CFG_LOCK];
         cfg_ff[VFDFC_CFG_BRST]  <= 1'b0;
         cfg_ff[VFDFC_CFG_CLEAR] <= 1'b0;
         cfg_ff[7]               <= 1'b0;
         if (!cfg_ff[VFDFC_CFG_LOCK]) begin
            cfg_ff[VFDFC_CFG_FONT] <= wdata[VFDFC_CFG_FONT];
            cfg_ff[VFDFC_CFG_ROW2] <= wdata[VFDFC_CFG_ROW2];
         end
      end
   end
   assign run       = cfg_ff[VFDFC_CFG_RUN];
   assign font_sel  = cfg_ff[VFDFC_CFG_FONT];
   assign row2_mode = cfg_ff[VFDFC_CFG_ROW2];

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cursor_ff <= VFDFC_CURSOR_RST;
      end else if (wr_evt && cmd == VFDFC_ADDR_CURSOR) begin
         cursor_ff <= wdata;
      end
   end

   // character store; global clear wins over a same-frame write
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < VFDFC_CHARS; i++) begin
            chr_ff[i] <= 8'h00;
         end
      end else if (clear_req) begin
         for (int i = 0; i < VFDFC_CHARS; i++) begin
            chr_ff[i] <= 8'h00;
         end
      end else if (wr_evt && chr_hit) begin
         chr_ff[chr_idx] <= wdata;
      end
   end

   // font pointer, holds at the last location with a stop flag set
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         fptr_ff  <= VFDFC_PTR_FIRST;
         fdone_ff <= 1'b0;
      end else if (font_ptr_wr) begin
         fdone_ff <= 1'b0;
         if (wdata >= VFDFC_PTR_BAD_LO) begin
            fptr_ff <= VFDFC_PTR_FIRST;
         end else begin
            fptr_ff <= wdata[5:0];
         end
      end else if (font_wr || font_rd) begin
         if (fptr_ff == VFDFC_PTR_LAST) begin
            fdone_ff <= 1'b1;
         end else begin
            fptr_ff <= fptr_ff + 6'h01;
         end
      end
   end

   // font entries, reachable from the host only through the port
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < VFDFC_GLYPHS; i++) begin
            font_ff[2*i]   <= VFDFC_FONT_INIT[i];
            font_ff[2*i+1] <= 7'h00;
         end
      end else if (font_wr) begin
         font_ff[fptr_ff] <= wdata[6:0];
      end
   end

   // blink timer, restartable from the configuration register
   assign blink_period = cfg_ff[VFDFC_CFG_BRATE] ? BW'(BLINK_FAST_CYC)
                                                 : BW'(BLINK_SLOW_CYC);
   always_comb begin
      nxt_blink = blink_ff + BW'(1);
      if (brst_req || nxt_blink >= blink_period) begin
         nxt_blink = '0;
      end
   end
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         blink_ff <= '0;
      end else begin
         blink_ff <= nxt_blink;
      end
   end
   assign blink_on = blink_ff < (blink_period >> 1);

   // display fetch, one cycle behind disp_idx
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         glyph_ff <= 7'h00;
         dp_ff    <= 1'b0;
         cur_ff   <= 1'b0;
      end else begin
         glyph_ff <= chr_ff[disp_idx][6:0];
         dp_ff    <= chr_ff[disp_idx][VFDFC_DP_BIT];
         cur_ff   <= (cursor_ff[6:0] == disp_idx)
                     && (cursor_ff[6:0] < VFDFC_CUR_OFF_LO)
                     && (row2_mode
                         || cursor_ff[6:0] < VFDFC_CUR_ROW2_LO)
                     && (!cursor_ff[VFDFC_CUR_BLINK] || blink_on);
      end
   end

   // field bit 0 lights the segment, bit 1 makes it blink
   for (genvar s = 0; s < 4; s++) begin : g_ann
      always_ff @(posedge clk_sys or posedge rst) begin
         if (rst) begin
            ann_ff[s] <= 1'b0;
         end else begin
            ann_ff[s] <= !row2_mode && disp_idx < 7'(VFDFC_ROW_LEN)
               && chr_ff[7'(disp_idx + 7'(VFDFC_ROW_LEN))][2*s]
               && (!chr_ff[7'(disp_idx + 7'(VFDFC_ROW_LEN))][2*s+1]
                   || blink_on);
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         gbits_ff <= 14'h0000;
      end else if (glyph_idx < 5'(VFDFC_GLYPHS)) begin
         gbits_ff <= {font_ff[{glyph_idx, 1'b1}],
                      font_ff[{glyph_idx, 1'b0}]};
      end else begin
         gbits_ff <= 14'h0000;
      end
   end

   assign disp_glyph  = glyph_ff;
   assign disp_dp     = dp_ff;
   assign disp_cursor = cur_ff;
   assign ann_lit     = ann_ff;
   assign glyph_bits  = gbits_ff;

   sequence s_ptr_load;
      font_ptr_wr && wdata < VFDFC_PTR_BAD_LO;
   endsequence
   sequence s_data_step;
      font_wr && !fdone_ff && fptr_ff != VFDFC_PTR_LAST;
   endsequence

   property p_ptr_load;
      @(posedge clk_sys) disable iff (rst)
      s_ptr_load |=> fptr_ff == $past(wdata[5:0]) && !fdone_ff;
   endproperty
   a_ptr_load: assert property (p_ptr_load)
      else $error("pointer load wrong");

   property p_ptr_clamp;
      @(posedge clk_sys) disable iff (rst)
      font_ptr_wr && wdata >= VFDFC_PTR_BAD_LO |=> fptr_ff == VFDFC_PTR_FIRST;
   endproperty
   a_ptr_clamp: assert property (p_ptr_clamp)
      else $error("bad pointer not clamped");

   property p_ptr_step;
      @(posedge clk_sys) disable iff (rst)
      s_data_step |=> fptr_ff == $past(fptr_ff) + 6'h01
                      && font_ff[$past(fptr_ff)] == $past(wdata[6:0]);
   endproperty
   a_ptr_step: assert property (p_ptr_step)
      else $error("font write did not store and advance");

   property p_stop;
      @(posedge clk_sys) disable iff (rst)
      fdone_ff && !font_ptr_wr |=> fdone_ff && $stable(fptr_ff);
   endproperty
   a_stop: assert property (p_stop)
      else $error("pointer moved after last location");

   property p_rd_msb;
      @(posedge clk_sys) disable iff (rst)
      sclk_rise && !cs_n && cnt_ff == 5'h07 && shift_ff[6]
         && {shift_ff[5:0], din} == VFDFC_ADDR_FONT[6:0]
      |=> rd_ff == {1'b0, font_ff[fptr_ff]} && !rd_ff[7];
   endproperty
   a_rd_msb: assert property (p_rd_msb)
      else $error("font read data wrong");

   property p_cursor_off;
      @(posedge clk_sys) disable iff (rst)
      cursor_ff[6:0] >= VFDFC_CUR_OFF_LO ##1 cursor_ff[6:0]
         >= VFDFC_CUR_OFF_LO |-> !disp_cursor;
   endproperty
   a_cursor_off: assert property (p_cursor_off)
      else $error("cursor lit at off position");

   property p_dp;
      @(posedge clk_sys) disable iff (rst)
      !clear_req && !wr_evt |=> disp_dp == $past(chr_ff[disp_idx][7]);
   endproperty
   a_dp: assert property (p_dp)
      else $error("decimal point mismatch");

   property p_clear;
      @(posedge clk_sys) disable iff (rst)
      clear_req |=> chr_ff[0] == 8'h00 && chr_ff[95] == 8'h00;
   endproperty
   a_clear: assert property (p_clear)
      else $error("clear left data");

   property p_ann_row2;
      @(posedge clk_sys) disable iff (rst)
      row2_mode ##1 row2_mode |-> ann_lit == 4'h0;
   endproperty
   a_ann_row2: assert property (p_ann_row2)
      else $error("annunciator lit in double-row mode");
endmodule

// ==== vfdfc_host.sv ====
`timescale 1ns/1ps
// host side of the serial link; frames are driven off the falling clock edge
module vfdfc_host (
   input  wire logic clk_sys, // system clock
   input  wire logic dout,    // read data from the block
   output logic      cs_n,    // frame select, low
   output logic      sclk,    // serial clock
   output logic      din      // serial data to the block
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      din  = 1'b1;
   end

   // one whole frame: command byte then data byte, msb first
   // sclk phases last three clocks so dout has settled before the rise
   task automatic xfer(input logic [7:0] cmd, input logic [7:0] dat,
                       output logic [7:0] rd);
      logic [15:0] sh;
      sh = {cmd, dat};
      rd = 8'h00;
      @(negedge clk_sys);
      cs_n = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         @(negedge clk_sys);
         sclk = 1'b0;
         din  = sh[i];
         repeat (3) @(negedge clk_sys);
         if (i < 8) begin
            rd[i] = dout;
         end
         sclk = 1'b1;
         repeat (2) @(negedge clk_sys);
      end
      @(negedge clk_sys);
      sclk = 1'b0;
      repeat (2) @(negedge clk_sys);
      cs_n = 1'b1;
      // released line must not keep looking like valid data
      din  = ~din;
      repeat (3) @(negedge clk_sys);
   endtask
endmodule

// ==== vfdfc_regs_bench.sv ====
`timescale 1ns/1ps
module vfdfc_regs_bench;
   import vfdfc_pkg::*;
   logic        clk_sys;
   logic        rst;
   logic        cs_n;
   logic        sclk;
   logic        din;
   logic        dout;
   logic [6:0]  disp_idx;
   logic [6:0]  disp_glyph;
   logic        disp_dp;
   logic        disp_cursor;
   logic [3:0]  ann_lit;
   logic [4:0]  glyph_idx;
   logic [13:0] glyph_bits;
   logic        font_sel;
   logic        run;
   logic        row2_mode;
   logic        blink_on;
   int          error_cnt;
   int          cmp_count;

   localparam int FAST_CYC = 8;

   vfdfc_regs #(.BLINK_SLOW_CYC(16), .BLINK_FAST_CYC(FAST_CYC)) dut (
      .clk_sys(clk_sys), .rst(rst), .cs_n(cs_n), .sclk(sclk), .din(din),
      .dout(dout), .disp_idx(disp_idx), .disp_glyph(disp_glyph),
      .disp_dp(disp_dp), .disp_cursor(disp_cursor), .ann_lit(ann_lit),
      .glyph_idx(glyph_idx), .glyph_bits(glyph_bits), .font_sel(font_sel),
      .run(run), .row2_mode(row2_mode), .blink_on(blink_on));

   vfdfc_host host (.clk_sys(clk_sys), .dout(dout), .cs_n(cs_n),
                    .sclk(sclk), .din(din));

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_pin(input logic [13:0] got, input logic [13:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] r;
      host.xfer(a, d, r);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] r;
      host.xfer(a | 8'h80, 8'h00, r);
      chk_reg(r, exp);
   endtask

   // display outputs are registered: allow one clock plus settling
   task automatic show(input logic [6:0] i);
      @(negedge clk_sys);
      disp_idx = i;
      repeat (2) @(negedge clk_sys);
   endtask

   task automatic glyph(input logic [4:0] g);
      @(negedge clk_sys);
      glyph_idx = g;
      repeat (2) @(negedge clk_sys);
   endtask

   task automatic end_test(input string n);
      $display("test %s done", n);
   endtask

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      logic [6:0] d;
      logic [7:0] v;
      logic       pb;
      int         n;
      error_cnt = 0;
      cmp_count = 0;
      rst       = 1'b1;
      disp_idx  = 7'h00;
      glyph_idx = 5'h00;
      repeat (2) @(negedge clk_sys);
      rst = 1'b0;
      repeat (2) @(negedge clk_sys);
      rd(VFDFC_ADDR_CURSOR, VFDFC_CURSOR_RST);
      rd(VFDFC_ADDR_CONFIG, VFDFC_CFG_RST);
      wr(VFDFC_ADDR_FONT, 8'h80);
      for (int i = 0; i < VFDFC_ENTRIES; i++) begin
         v = i[0] ? 8'h00 : {1'b0, VFDFC_FONT_INIT[i / 2]};
         rd(VFDFC_ADDR_FONT, v);
      end
      rd(VFDFC_ADDR_FONT, 8'h00);
      glyph(5'd0);
      chk_pin(glyph_bits, {7'h00, VFDFC_FONT_INIT[0]});
      end_test("reset");

      wr(VFDFC_ADDR_FONT, 8'h82);
      wr(VFDFC_ADDR_FONT, 8'h55);
      wr(VFDFC_ADDR_FONT, 8'h2a);
      glyph(5'd1);
      chk_pin(glyph_bits, {7'h2a, 7'h55});
      wr(VFDFC_ADDR_FONT, 8'h83);
      rd(VFDFC_ADDR_FONT, 8'h2a);
      rd(VFDFC_ADDR_FONT, {1'b0, VFDFC_FONT_INIT[2]});
      wr(VFDFC_ADDR_FONT, 8'hae);
      wr(VFDFC_ADDR_FONT, 8'h11);
      wr(VFDFC_ADDR_FONT, 8'h33);
      wr(VFDFC_ADDR_FONT, 8'h44);
      glyph(5'd23);
      chk_pin(glyph_bits, {7'h33, 7'h11});
      wr(VFDFC_ADDR_FONT, 8'haf);
      rd(VFDFC_ADDR_FONT, 8'h33);
      rd(VFDFC_ADDR_FONT, 8'h33);
      wr(VFDFC_ADDR_FONT, 8'hc5);
      rd(VFDFC_ADDR_FONT, {1'b0, VFDFC_FONT_INIT[0]});
      wr(8'h10, 8'h5a);
      rd(8'h10, 8'h00);
      end_test("font");

      for (int i = 0; i < 4; i++) begin
         d = 7'(i * 47 / 3);
         v = {i[0], 7'(i * 37 + 1)};
         wr(VFDFC_ADDR_CHAR_LO + 8'(d), v);
         show(d);
         chk_pin(14'(disp_glyph), 14'(v[6:0]));
         chk_pin(14'(disp_dp), 14'(v[7]));
         rd(VFDFC_ADDR_CHAR_LO + 8'(d), v);
      end
      for (int s = 0; s < 4; s++) begin
         wr(8'h50, 8'(1 << (2 * s)));
         show(7'd0);
         chk_pin(14'(ann_lit), 14'(1 << s));
      end
      wr(VFDFC_ADDR_CONFIG, 8'h41);
      chk_pin(14'(row2_mode), 14'h0001);
      wr(8'h50, 8'h85);
      show(7'd48);
      chk_pin(14'(disp_glyph), 14'h0005);
      chk_pin(14'(disp_dp), 14'h0001);
      show(7'd0);
      chk_pin(14'(ann_lit), 14'h0000);
      end_test("chars");

      wr(VFDFC_ADDR_CURSOR, 8'h05);
      show(7'd5);
      chk_pin(14'(disp_cursor), 14'h0001);
      show(7'd6);
      chk_pin(14'(disp_cursor), 14'h0000);
      wr(VFDFC_ADDR_CURSOR, 8'h35);
      show(7'd53);
      chk_pin(14'(disp_cursor), 14'h0001);
      wr(VFDFC_ADDR_CURSOR, 8'h5f);
      show(7'd95);
      chk_pin(14'(disp_cursor), 14'h0001);
      wr(VFDFC_ADDR_CURSOR, 8'h60);
      show(7'd95);
      chk_pin(14'(disp_cursor), 14'h0000);
      wr(VFDFC_ADDR_CONFIG, 8'h45);
      wr(VFDFC_ADDR_CURSOR, 8'h85);
      show(7'd5);
      pb = blink_on;
      repeat (40) begin
         @(negedge clk_sys);
         if (blink_on === pb)
            chk_pin(14'(disp_cursor), 14'(pb));
         pb = blink_on;
      end
      // restart lands at frame end, two counts before wr returns
      wr(VFDFC_ADDR_CONFIG, 8'h4d);
      n = 0;
      while (n < 20 && blink_on === 1'b1) begin
         n++;
         @(negedge clk_sys);
      end
      chk_pin(14'(n), 14'(FAST_CYC / 2 - 2));
      n = 0;
      while (n < 20 && blink_on === 1'b0) begin
         n++;
         @(negedge clk_sys);
      end
      chk_pin(14'(n), 14'(FAST_CYC / 2));
      n = 0;
      while (n < 20 && blink_on === 1'b1) begin
         n++;
         @(negedge clk_sys);
      end
      chk_pin(14'(n), 14'(FAST_CYC / 2));
      end_test("cursor");

      wr(VFDFC_ADDR_CONFIG, 8'h03);
      chk_pin(14'({run, font_sel, row2_mode}), 14'h0006);
      rd(VFDFC_ADDR_CONFIG, 8'h03);
      wr(VFDFC_ADDR_CONFIG, 8'h23);
      wr(VFDFC_ADDR_CONFIG, 8'h61);
      chk_pin(14'({font_sel, row2_mode}), 14'h0002);
      wr(VFDFC_ADDR_CONFIG, 8'h10);
      chk_pin(14'(run), 14'h0000);
      rd(VFDFC_ADDR_CHAR_LO, 8'h00);
      rd(VFDFC_ADDR_CHAR_SHI, 8'h00);
      rd(8'h50, 8'h00);
      end_test("config");
      stop_test();
   end
endmodule
